// ### hw/jtag_isp_instruction_decoder.sv
// Test port instruction decoder with boundary-scan and in-system programming paths
//
// Notes on behaviour
// [R1] Identification code selects the 32-bit identification register onto the serial path.
// [R2] Structure test code selects the boundary chain; reserved for factory use.
// [R3] High-impedance code puts every system output in its inactive drive state.
// [R4] High-impedance code puts the one-bit bypass stage on the serial path.
// [R5] Enable code selects the programming register and arms erase, program, verify.
// [R6] Armed erase, program, verify make outputs follow the preloaded boundary values.
// [R7] Armed erase empties the whole nonvolatile array in one operation.
// [R8] Armed program writes the register's data into the row it addresses.
// [R9] Armed verify copies the addressed row into the register for shifting out.
// [R10] Bypass passes serial input to output through one half-cycle stage.
// [R11] Host programs: enable, program, then address and data per row, execute.
// [R12] Host verifies: enable, verify, address per row, execute, shift out, compare.
// [R13] User signature lives in row 41, read side A then side B.
// [R14] Host secures by programming the security row with only that bit programmed.
// [R15] Only low-level instructions exist here; the host builds the larger operations.
// [R16] Four-bit instruction; unused codes behave as bypass.
// [R17] Armed state persists until the controller passes through its reset state.
// [R18] External test 0000, sample/preload 0010, bypass 1111 select their registers.
// [R19] Programming codes while unarmed leave the array untouched and act as bypass.
`timescale 1ns/100ps
`include "jtag_isp_consts.svh"

module jtag_isp_instruction_decoder #(
  parameter int          ROW_BITS = `ROW_DATA_W,
  parameter int          ADDR_W   = `ROW_ADDR_W,
  // Identification value is arbitrary; bit 0 must stay set
  parameter logic [31:0] ID_VALUE = 32'h0A5A_5001
) (
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  input  wire logic                     tck_in,
  input  wire logic                     tms_in,
  input  wire logic                     tdi_in,
  output logic                          tdo_out,
  output logic                          tdo_oe_out,
  input  wire logic                     bsr_tdo_in,
  output jtag_isp_pkg::bsr_ctrl_s       bsr_ctrl_out,
  output logic                          highz_out,
  output logic                          preload_drive_out,
  output logic                          isp_armed_out
);

  localparam int ISP_W = ADDR_W + ROW_BITS;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and test clock edges

  // Test clock is far slower than clk_in, so edges are found by sampling
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  logic       tck_rise;
  logic       tck_fall;
  logic       tms_s;
  logic       tdi_s;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tdi_q <= 2'h3;
    end else begin
      tck_q <= {tck_q[1:0], tck_in};
      tms_q <= {tms_q[0], tms_in};
      tdi_q <= {tdi_q[0], tdi_in};
    end
  end

  assign tck_rise = tck_q[1] & ~tck_q[2];
  assign tck_fall = ~tck_q[1] & tck_q[2];
  assign tms_s    = tms_q[1];
  assign tdi_s    = tdi_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Test controller

  jtag_isp_pkg::tap_state_e tap_q;
  jtag_isp_pkg::tap_state_e tap_d;

  always_comb begin
    tap_d = tap_q;
    unique case (tap_q)
      jtag_isp_pkg::TAP_RESET:  tap_d = tms_s ? jtag_isp_pkg::TAP_RESET  : jtag_isp_pkg::TAP_IDLE;
      jtag_isp_pkg::TAP_IDLE:   tap_d = tms_s ? jtag_isp_pkg::TAP_SEL_DR : jtag_isp_pkg::TAP_IDLE;
      jtag_isp_pkg::TAP_SEL_DR: tap_d = tms_s ? jtag_isp_pkg::TAP_SEL_IR : jtag_isp_pkg::TAP_CAP_DR;
      jtag_isp_pkg::TAP_CAP_DR: tap_d = tms_s ? jtag_isp_pkg::TAP_EX1_DR : jtag_isp_pkg::TAP_SH_DR;
      jtag_isp_pkg::TAP_SH_DR:  tap_d = tms_s ? jtag_isp_pkg::TAP_EX1_DR : jtag_isp_pkg::TAP_SH_DR;
      jtag_isp_pkg::TAP_EX1_DR: tap_d = tms_s ? jtag_isp_pkg::TAP_UPD_DR : jtag_isp_pkg::TAP_PAU_DR;
      jtag_isp_pkg::TAP_PAU_DR: tap_d = tms_s ? jtag_isp_pkg::TAP_EX2_DR : jtag_isp_pkg::TAP_PAU_DR;
      jtag_isp_pkg::TAP_EX2_DR: tap_d = tms_s ? jtag_isp_pkg::TAP_UPD_DR : jtag_isp_pkg::TAP_SH_DR;
      jtag_isp_pkg::TAP_UPD_DR: tap_d = tms_s ? jtag_isp_pkg::TAP_SEL_DR : jtag_isp_pkg::TAP_IDLE;
      jtag_isp_pkg::TAP_SEL_IR: tap_d = tms_s ? jtag_isp_pkg::TAP_RESET  : jtag_isp_pkg::TAP_CAP_IR;
      jtag_isp_pkg::TAP_CAP_IR: tap_d = tms_s ? jtag_isp_pkg::TAP_EX1_IR : jtag_isp_pkg::TAP_SH_IR;
      jtag_isp_pkg::TAP_SH_IR:  tap_d = tms_s ? jtag_isp_pkg::TAP_EX1_IR : jtag_isp_pkg::TAP_SH_IR;
      jtag_isp_pkg::TAP_EX1_IR: tap_d = tms_s ? jtag_isp_pkg::TAP_UPD_IR : jtag_isp_pkg::TAP_PAU_IR;
      jtag_isp_pkg::TAP_PAU_IR: tap_d = tms_s ? jtag_isp_pkg::TAP_EX2_IR : jtag_isp_pkg::TAP_PAU_IR;
      jtag_isp_pkg::TAP_EX2_IR: tap_d = tms_s ? jtag_isp_pkg::TAP_UPD_IR : jtag_isp_pkg::TAP_SH_IR;
      jtag_isp_pkg::TAP_UPD_IR: tap_d = tms_s ? jtag_isp_pkg::TAP_SEL_DR : jtag_isp_pkg::TAP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tap_q <= jtag_isp_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction register and arming

  logic [`IR_W-1:0] ir_sr_q;
  logic [`IR_W-1:0] ir_q;
  logic             armed_q;
  logic             isp_op;
  jtag_isp_pkg::reg_sel_e sel;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ir_sr_q <= `IR_CAPTURE;
      ir_q    <= `IR_RESET_OP;
    end else if (tap_q == jtag_isp_pkg::TAP_RESET) begin
      ir_q    <= `IR_RESET_OP;
    end else if (tck_rise) begin
      if (tap_q == jtag_isp_pkg::TAP_CAP_IR) begin
        ir_sr_q <= `IR_CAPTURE;
      end else if (tap_q == jtag_isp_pkg::TAP_SH_IR) begin
        ir_sr_q <= {tdi_s, ir_sr_q[`IR_W-1:1]};
      end else if (tap_q == jtag_isp_pkg::TAP_UPD_IR) begin
        ir_q    <= ir_sr_q;
      end
    end
  end

  // Arming survives later instruction loads; only the reset state drops it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed_q <= 1'b0;
    end else if (tap_q == jtag_isp_pkg::TAP_RESET) begin
      armed_q <= 1'b0; // see [R17]
    end else if (tck_rise && tap_q == jtag_isp_pkg::TAP_UPD_IR && ir_sr_q == `OP_ENABLE) begin
      armed_q <= 1'b1; // see [R5]
    end
  end

  assign isp_op = (ir_q == `OP_ERASE) || (ir_q == `OP_PROGRAM) || (ir_q == `OP_VERIFY);

  // Only low-level codes decode here; anything unlisted falls to bypass
  always_comb begin
    sel = jtag_isp_pkg::SEL_BYPASS; // see [R15]
    case (ir_q)
      `OP_EXTEST, `OP_SAMPLE, `OP_STRUCT: sel = jtag_isp_pkg::SEL_BSR; // see [R2] [R18]
      `OP_IDCODE:                         sel = jtag_isp_pkg::SEL_ID; // see [R1]
      `OP_ENABLE:                         sel = jtag_isp_pkg::SEL_ISP; // see [R5]
      `OP_ERASE, `OP_PROGRAM, `OP_VERIFY: begin
        sel = armed_q ? jtag_isp_pkg::SEL_ISP : jtag_isp_pkg::SEL_BYPASS; // see [R19]
      end
      default:                            sel = jtag_isp_pkg::SEL_BYPASS; // see [R4] [R16]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data registers

  logic [`ID_W-1:0]    id_sr_q;
  logic                byp_q;
  logic [ISP_W-1:0]    isp_sr_q;
  logic [ROW_BITS-1:0] row_rd;
  logic                dr_shift;
  logic                exec;
  logic                erase_go;
  logic                prog_go;
  logic                ver_go;

  assign dr_shift = tck_rise && tap_q == jtag_isp_pkg::TAP_SH_DR;
  // Operations fire on update, and only when armed
  assign exec     = tck_rise && tap_q == jtag_isp_pkg::TAP_UPD_DR && armed_q;
  assign erase_go = exec && ir_q == `OP_ERASE; // see [R7] [R19]
  assign prog_go  = exec && ir_q == `OP_PROGRAM; // see [R8] [R11] [R14]
  assign ver_go   = exec && ir_q == `OP_VERIFY; // see [R9] [R12]

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      id_sr_q <= '0;
    end else if (tck_rise && tap_q == jtag_isp_pkg::TAP_CAP_DR && sel == jtag_isp_pkg::SEL_ID) begin
      id_sr_q <= ID_VALUE; // see [R1]
    end else if (dr_shift && sel == jtag_isp_pkg::SEL_ID) begin
      id_sr_q <= {tdi_s, id_sr_q[`ID_W-1:1]};
    end
  end

  // Bypass stage takes data on the rising edge and shows it on the falling one
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      byp_q <= `BYPASS_CAP;
    end else if (tck_rise && tap_q == jtag_isp_pkg::TAP_CAP_DR && sel == jtag_isp_pkg::SEL_BYPASS) begin
      byp_q <= `BYPASS_CAP;
    end else if (dr_shift && sel == jtag_isp_pkg::SEL_BYPASS) begin
      byp_q <= tdi_s; // see [R10]
    end
  end

  // Capture leaves the programming register alone so verified data can be read back
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      isp_sr_q <= '0;
    end else if (ver_go) begin
      isp_sr_q[ROW_BITS-1:0] <= row_rd; // see [R9] [R13]
    end else if (dr_shift && sel == jtag_isp_pkg::SEL_ISP) begin
      isp_sr_q <= {tdi_s, isp_sr_q[ISP_W-1:1]};
    end
  end

  isp_row_store #(
    .ROW_BITS (ROW_BITS),
    .ADDR_W   (ADDR_W)
  ) u_store (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .erase_in    (erase_go),
    .write_in    (prog_go),
    .addr_in     (isp_sr_q[ISP_W-1 -: ADDR_W]),
    .wr_data_in  (isp_sr_q[ROW_BITS-1:0]),
    .rd_data_out (row_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output, boundary chain strobes and output control

  logic serial_bit;
  logic bsr_sel;

  assign bsr_sel = sel == jtag_isp_pkg::SEL_BSR;

  always_comb begin
    serial_bit = byp_q;
    unique case (sel)
      jtag_isp_pkg::SEL_BYPASS: serial_bit = byp_q;
      jtag_isp_pkg::SEL_ID:     serial_bit = id_sr_q[0];
      jtag_isp_pkg::SEL_BSR:    serial_bit = bsr_tdo_in;
      jtag_isp_pkg::SEL_ISP:    serial_bit = isp_sr_q[0];
    endcase
    if (tap_q == jtag_isp_pkg::TAP_SH_IR) begin
      serial_bit = ir_sr_q[0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out    <= serial_bit; // see [R10]
      tdo_oe_out <= tap_q == jtag_isp_pkg::TAP_SH_DR || tap_q == jtag_isp_pkg::TAP_SH_IR;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bsr_ctrl_out <= '0;
    end else begin
      bsr_ctrl_out.capture        <= tck_rise && tap_q == jtag_isp_pkg::TAP_CAP_DR && bsr_sel;
      bsr_ctrl_out.shift          <= dr_shift && bsr_sel;
      bsr_ctrl_out.update         <= tck_rise && tap_q == jtag_isp_pkg::TAP_UPD_DR && bsr_sel;
      bsr_ctrl_out.tdi            <= tdi_s;
      bsr_ctrl_out.extest         <= ir_q == `OP_EXTEST; // see [R18]
      bsr_ctrl_out.integrity_test <= ir_q == `OP_STRUCT; // see [R2]
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      highz_out         <= 1'b0;
      preload_drive_out <= 1'b0;
      isp_armed_out     <= 1'b0;
    end else begin
      highz_out         <= ir_q == `OP_HIGHZ; // see [R3]
      preload_drive_out <= ir_q == `OP_EXTEST || (armed_q && isp_op); // see [R6]
      isp_armed_out     <= armed_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_idcode_select: // see [R1]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (ir_q == `OP_IDCODE) |-> (sel == jtag_isp_pkg::SEL_ID))
    else $error("identification code did not select its register");

  a_struct_select: // see [R2]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (ir_q == `OP_STRUCT) |-> (sel == jtag_isp_pkg::SEL_BSR))
    else $error("structure test did not select boundary chain");

  a_highz_drive: // see [R3]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (ir_q == `OP_HIGHZ) [*2] |-> highz_out && !preload_drive_out)
    else $error("outputs not released under high impedance");

  a_highz_bypass: // see [R4]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      highz_out |-> $past(sel == jtag_isp_pkg::SEL_BYPASS))
    else $error("high impedance without bypass path");

  a_enable_arm: // see [R5]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (tck_rise && tap_q == jtag_isp_pkg::TAP_UPD_IR && ir_sr_q == `OP_ENABLE)
        |=> armed_q && sel == jtag_isp_pkg::SEL_ISP)
    else $error("enable did not arm programming");

  a_preload_drive: // see [R6]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (armed_q && isp_op) |=> preload_drive_out)
    else $error("preloaded outputs not used during programming");

  a_verify_load: // see [R9]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      ver_go |=> (isp_sr_q[ROW_BITS-1:0] == $past(row_rd)))
    else $error("verify did not load the addressed row");

  a_bypass_pass: // see [R10]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (tck_fall && tap_q == jtag_isp_pkg::TAP_SH_DR && sel == jtag_isp_pkg::SEL_BYPASS)
        |=> (tdo_out == $past(byp_q)) && tdo_oe_out)
    else $error("bypass stage not driven on falling edge");

  a_unused_bypass: // see [R16]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (ir_q inside {4'h3, 4'h6, 4'h7, 4'h8, 4'hD, 4'hE}) |-> (sel == jtag_isp_pkg::SEL_BYPASS))
    else $error("unused code not treated as bypass");

  a_arm_clear: // see [R17]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (tap_q == jtag_isp_pkg::TAP_RESET) |=> !armed_q ##1 !isp_armed_out)
    else $error("arming survived controller reset");

  a_unarmed_bypass: // see [R19]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (!armed_q && isp_op) |-> (sel == jtag_isp_pkg::SEL_BYPASS) && !erase_go && !prog_go)
    else $error("unarmed programming code acted");

endmodule

// ### hw/jtag_isp_consts.svh
// Instruction codes, field widths and reset values for the test port decoder
`ifndef JTAG_ISP_CONSTS_SVH
`define JTAG_ISP_CONSTS_SVH

`define IR_W          4
`define OP_EXTEST     4'h0
`define OP_IDCODE     4'h1
`define OP_SAMPLE     4'h2
`define OP_STRUCT     4'h4
`define OP_HIGHZ      4'h5
`define OP_ENABLE     4'h9
`define OP_ERASE      4'hA
`define OP_PROGRAM    4'hB
`define OP_VERIFY     4'hC
`define OP_BYPASS     4'hF
`define IR_CAPTURE    4'h1
`define IR_RESET_OP   4'h1
`define ID_W          32
`define ROW_DATA_W    1028
`define ROW_ADDR_W    7
`define ISP_ROWS      43
`define USER_SIG_ROW  6'h29
`define BYPASS_CAP    1'h0

`endif

// ### hw/jtag_isp_pkg.sv
// Types shared by the test port decoder and its testbench
package jtag_isp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'b1111,
    TAP_IDLE    = 4'b1100,
    TAP_SEL_DR  = 4'b0111,
    TAP_CAP_DR  = 4'b0110,
    TAP_SH_DR   = 4'b0010,
    TAP_EX1_DR  = 4'b0001,
    TAP_PAU_DR  = 4'b0011,
    TAP_EX2_DR  = 4'b0000,
    TAP_UPD_DR  = 4'b0101,
    TAP_SEL_IR  = 4'b0100,
    TAP_CAP_IR  = 4'b1110,
    TAP_SH_IR   = 4'b1010,
    TAP_EX1_IR  = 4'b1001,
    TAP_PAU_IR  = 4'b1011,
    TAP_EX2_IR  = 4'b1000,
    TAP_UPD_IR  = 4'b1101
  } tap_state_e;

  typedef enum logic [1:0] {
    SEL_BYPASS = 2'b00,
    SEL_ID     = 2'b01,
    SEL_BSR    = 2'b10,
    SEL_ISP    = 2'b11
  } reg_sel_e;

  // Strobes and modes toward the external boundary cell chain
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic tdi;
    logic extest;
    logic integrity_test;
  } bsr_ctrl_s;

endpackage

// ### hw/isp_row_store.sv
// Nonvolatile row array model: bulk erase, row program and row read
`timescale 1ns/100ps
`include "jtag_isp_consts.svh"

module isp_row_store #(
  parameter int ROW_BITS = `ROW_DATA_W,
  parameter int ADDR_W   = `ROW_ADDR_W,
  parameter int ROWS     = `ISP_ROWS
) (
  input  wire logic                clk_in,
  input  wire logic                rstn_in,
  input  wire logic                erase_in,
  input  wire logic                write_in,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [ROW_BITS-1:0] wr_data_in,
  output logic      [ROW_BITS-1:0] rd_data_out
);

  localparam int DEPTH = 2 ** ADDR_W;

  logic [ROW_BITS-1:0] mem_q [0:DEPTH-1];
  logic [DEPTH-1:0]    valid_q;
  logic                in_range;

  // Top address bit picks the side, the rest the row; user signature row is ordinary storage
  assign in_range = addr_in[ADDR_W-2:0] < ROWS; // see [R13]

  // Erase clears one flag per entry so the whole array empties in one cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      valid_q <= '0;
    end else if (erase_in) begin
      valid_q <= '0; // see [R7]
    end else if (write_in && in_range) begin
      valid_q[addr_in] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (write_in && in_range && !erase_in) begin
      mem_q[addr_in] <= wr_data_in; // see [R8]
    end
  end

  assign rd_data_out = valid_q[addr_in] ? mem_q[addr_in] : '0;

  a_erase_empties: // see [R7]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      erase_in |=> (valid_q == '0))
    else $error("erase left a row programmed");

  a_program_lands: // see [R8]
    assert property (@(posedge clk_in) disable iff (!rstn_in)
      (write_in && in_range && !erase_in) |=> valid_q[$past(addr_in)])
    else $error("programmed row not marked written");

endmodule

// ### tb/jtag_host_model.sv
// Test port host model: drives test clock, mode and serial data, samples serial out
`timescale 1ns/100ps

module jtag_host_model (
  input  wire logic clk_in,
  input  wire logic tdo_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out
);
  localparam int HALF_CLKS = 20;

  initial begin
    tck_out = 1'h0;
    tms_out = 1'h1;
    tdi_out = 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test clock rests low, so it stands still between frames
  task automatic step(input logic mode, input logic data, output logic seen);
    @(posedge clk_in);
    tms_out <= mode;
    tdi_out <= data;
    // The edge wait above already spent one cycle of the low half
    repeat (HALF_CLKS - 1) @(posedge clk_in);
    seen = tdo_in;
    tck_out <= 1'h1;
    repeat (HALF_CLKS) @(posedge clk_in);
    tck_out <= 1'h0;
  endtask

  task automatic reset_tap();
    logic s;
    repeat (5) step(1'h1, 1'h1, s);
    step(1'h0, 1'h1, s);
  endtask

  // From idle, shift n bits lsb first, pass through update, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic s;
    dout = '0;
    step(1'h1, 1'h1, s);
    if (is_ir) begin
      step(1'h1, 1'h1, s);
    end
    step(1'h0, 1'h1, s);
    step(1'h0, 1'h1, s);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], s);
      dout[i] = s;
    end
    step(1'h1, 1'h1, s);
    step(1'h0, 1'h1, s);
  endtask
endmodule

// ### tb/jtag_isp_instruction_decoder_tb.sv
// Self-checking bench for the test port instruction decoder
`timescale 1ns/100ps
`include "jtag_isp_consts.svh"

module jtag_isp_instruction_decoder_tb;
  localparam int          RB        = 16;
  localparam int          AW        = 7;
  localparam int          DRW       = RB + AW;
  // Identification value is arbitrary; bit 0 kept set
  localparam logic [31:0] ID_VAL    = 32'h1357_9BDF;
  localparam logic [7:0]  CHAIN_CAP = 8'hA5;
  localparam logic [7:0]  PAT       = 8'h3C;
  // Row 41 side A, row 41 side B, row 42 with a single programmed bit
  localparam logic [6:0]  ROWS [3]  = '{7'h29, 7'h69, 7'h2A};
  localparam logic [15:0] VALS [3]  = '{16'hC3A5, 16'h5A0F, 16'h0001};

  logic                    clk_in, rstn_in, tck, tms, tdi, tdo_out, tdo_oe_out, tdo_w;
  logic                    bsr_tdo_in, highz_out, preload_drive_out, isp_armed_out;
  jtag_isp_pkg::bsr_ctrl_s bsr_ctrl_out;
  logic [7:0]              chain_q = 8'h00;
  logic [7:0]              upd_q   = 8'h00;
  logic [63:0]             got;
  logic [RB-1:0]           d;
  int                      err_count;
  int                      num_checks;

  // Serial out has a pull-up when released
  assign tdo_w      = tdo_oe_out ? tdo_out : 1'h1;
  assign bsr_tdo_in = chain_q[0];

  jtag_isp_instruction_decoder #(.ROW_BITS(RB), .ADDR_W(AW), .ID_VALUE(ID_VAL)) dut (
    .clk_in            (clk_in),
    .rstn_in           (rstn_in),
    .tck_in            (tck),
    .tms_in            (tms),
    .tdi_in            (tdi),
    .tdo_out           (tdo_out),
    .tdo_oe_out        (tdo_oe_out),
    .bsr_tdo_in        (bsr_tdo_in),
    .bsr_ctrl_out      (bsr_ctrl_out),
    .highz_out         (highz_out),
    .preload_drive_out (preload_drive_out),
    .isp_armed_out     (isp_armed_out)
  );

  jtag_host_model host (
    .clk_in  (clk_in),
    .tdo_in  (tdo_w),
    .tck_out (tck),
    .tms_out (tms),
    .tdi_out (tdi)
  );

  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end

  // Short external boundary chain with a known capture pattern
  always @(posedge clk_in) begin
    if (bsr_ctrl_out.capture) begin
      chain_q <= CHAIN_CAP;
    end else if (bsr_ctrl_out.shift) begin
      chain_q <= {bsr_ctrl_out.tdi, chain_q[7:1]};
    end
    // Update strobe latches what was shifted in, as a real chain would
    if (bsr_ctrl_out.update) begin
      upd_q <= chain_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("FAIL %0t %s seen %0h expected %0h", $time, what, seen, want);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic load_ir(input logic [3:0] code);
    host.scan(1'h1, 4, {60'h0, code}, got);
  endtask

  task automatic arm();
    load_ir(`OP_ENABLE);
    check(64'(isp_armed_out), 64'h1, "armed");
  endtask

  task automatic write_row(input logic [6:0] a, input logic [RB-1:0] v);
    host.scan(1'h0, DRW, {41'h0, a, v}, got);
  endtask

  // First scan executes the read, second shifts the row out
  task automatic read_row(input logic [6:0] a, output logic [RB-1:0] v);
    host.scan(1'h0, DRW, {41'h0, a, 16'h0000}, got);
    host.scan(1'h0, DRW, {41'h0, a, 16'h0000}, got);
    v = got[RB-1:0];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_id();
    host.scan(1'h0, 32, 64'h0, got);
    check(got, {32'h0, ID_VAL}, "id readout");
    load_ir(`OP_BYPASS);
    check(got, {60'h0, `IR_CAPTURE}, "ir capture");
  endtask

  task automatic t_bypass();
    logic [3:0] codes [10] = '{`OP_BYPASS, 4'h3, 4'h6, 4'h7, 4'h8, 4'hD, 4'hE,
                               `OP_ERASE, `OP_PROGRAM, `OP_VERIFY};
    for (int i = 0; i < 10; i++) begin
      load_ir(codes[i]);
      host.scan(1'h0, 8, {56'h0, PAT}, got);
      check(got, {56'h0, PAT[6:0], `BYPASS_CAP}, "bypass path");
      check(64'(isp_armed_out), 64'h0, "unarmed");
    end
  endtask

  task automatic t_highz();
    load_ir(`OP_HIGHZ);
    check(64'(highz_out), 64'h1, "highz on");
    host.scan(1'h0, 8, {56'h0, PAT}, got);
    check(got, {56'h0, PAT[6:0], `BYPASS_CAP}, "highz path");
    load_ir(`OP_BYPASS);
    check(64'(highz_out), 64'h0, "highz off");
  endtask

  task automatic t_boundary();
    logic [3:0] codes [3] = '{`OP_EXTEST, `OP_SAMPLE, `OP_STRUCT};
    logic [2:0] mode_want;
    logic [2:0] mode_seen;
    for (int i = 0; i < 3; i++) begin
      load_ir(codes[i]);
      host.scan(1'h0, 8, {56'h0, PAT}, got);
      check(got, {56'h0, CHAIN_CAP}, "boundary path");
      check(64'(upd_q), 64'(PAT), "boundary update");
      mode_want = {codes[i] == `OP_EXTEST, codes[i] == `OP_STRUCT, codes[i] == `OP_EXTEST};
      mode_seen = {bsr_ctrl_out.extest, bsr_ctrl_out.integrity_test, preload_drive_out};
      check(64'(mode_seen), 64'(mode_want), "boundary mode");
    end
  endtask

  task automatic t_program();
    host.reset_tap();
    arm();
    load_ir(`OP_PROGRAM);
    check(64'(preload_drive_out), 64'h1, "preload drive");
    for (int i = 0; i < 3; i++) begin
      write_row(ROWS[i], VALS[i]);
    end
    load_ir(`OP_VERIFY);
    check(64'(isp_armed_out), 64'h1, "armed kept");
    for (int i = 0; i < 3; i++) begin
      read_row(ROWS[i], d);
      check(64'(d), 64'(VALS[i]), "row readback");
    end
  endtask

  // Programming codes without arming must not touch stored rows
  task automatic t_unarmed();
    host.reset_tap();
    check(64'(isp_armed_out), 64'h0, "disarmed by reset");
    load_ir(`OP_ERASE);
    write_row(ROWS[0], 16'h0000);
    load_ir(`OP_PROGRAM);
    write_row(ROWS[0], ~VALS[0]);
    arm();
    load_ir(`OP_VERIFY);
    read_row(ROWS[0], d);
    check(64'(d), 64'(VALS[0]), "row untouched");
  endtask

  task automatic t_erase();
    load_ir(`OP_ERASE);
    write_row(ROWS[1], 16'hFFFF);
    load_ir(`OP_VERIFY);
    for (int i = 0; i < 3; i++) begin
      read_row(ROWS[i], d);
      check(64'(d), 64'h0, "erased row");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_in = 1'h0;
    err_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'h1;
    repeat (4) @(posedge clk_in);
    host.reset_tap();
    t_id();
    t_bypass();
    t_highz();
    t_boundary();
    t_program();
    t_unarmed();
    t_erase();
    end_sim();
  end

  // Expected run is about 42000 cycles; the limit of 75000 cycles is less than twice that
  initial begin
    #300000;
    err_count++;
    end_sim();
  end
endmodule
